// ---- inc/ttf_pkg.sv ----
// Purpose: Shared constants and types of the timing track formatter
// Assumes: 20 MHz system clock
// Notes:   Register offsets are word indices on the plain register port
package ttf_pkg;

   // Clock and timing
   localparam int unsigned CLK_NS       = 50;
   localparam int unsigned ERASE_MS     = 100;
   localparam int unsigned ERASE_CYC    = ERASE_MS * 1000 * 1000 / CLK_NS;
   localparam int unsigned SHORT_US     = 250;
   localparam int unsigned SHORT_CYC    = (SHORT_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int unsigned LONG_US      = 350;
   localparam int unsigned LONG_CYC     = LONG_US * 1000 / CLK_NS;
   localparam int unsigned RECOVER_US   = 20;
   localparam int unsigned RECOVER_CYC  = (RECOVER_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int unsigned CELL_NS      = 800;
   localparam logic [7:0]  QUARTER_CYC  = 8'(CELL_NS / 4 / CLK_NS);

   // Format
   localparam int unsigned ADDR_W       = 11;
   localparam int unsigned SEGMENTS     = 2048;
   localparam logic [4:0]  CELL_START   = 5'h00;
   localparam logic [4:0]  CELL_ADDR_LO = 5'h01;
   localparam logic [4:0]  CELL_ADDR_END= 5'h0b;
   localparam logic [4:0]  CELL_PARITY  = 5'h0c;
   localparam logic [4:0]  CELL_DELIM_P = 5'h0f;
   localparam logic [4:0]  CELL_DELIM_N = 5'h10;
   localparam logic [4:0]  CELL_PREARM  = 5'h13;

   // Register map
   localparam logic [3:0]  REG_CTRL     = 4'h0;
   localparam logic [3:0]  REG_STATUS   = 4'h1;
   localparam logic [3:0]  REG_ADDRESS  = 4'h2;
   localparam logic [3:0]  REG_BITCELL  = 4'h3;
   localparam int unsigned CTRL_SWITCH  = 0;
   localparam int unsigned CTRL_QTR_LSB = 8;
   localparam logic [15:0] CTRL_RESET   = {QUARTER_CYC, 8'h00};

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_ERASE   = 3'b001,
      ST_WRITE   = 3'b010,
      ST_RECOVER = 3'b011,
      ST_MEASURE = 3'b100,
      ST_DONE    = 3'b101
   } ttf_state_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } ttf_bus_t;

   typedef struct packed {
      logic aTrack;
      logic bTrack;
      logic cTrack;
      logic writeGate;
      logic erase;
   } ttf_heads_t;

endpackage

// ---- hdl/ttf_formatter.sv ----
// Purpose: Timing track formatter, writes clock, address and delimiter tracks
// Assumes: One 20 MHz clock, read amplifier output arrives asynchronously
// Notes:   Head writers are NRZ flip-flops; a one is one toggle
//
// How it works
// - One revolution holds 2048 segments, addresses 0 to octal 3777.
// - Each recorded address names the following segment, read ahead by the controller.
// - Address starts with control bit one; data word starts with guard zero.
// - Address and word end with a parity bit giving even ones.
// - Address recording starts at bit-cell count 0, data bit 14.
// - Delimiter track pulses sit at bit-cell counts 15 and 16.
// - Clock, 11-bit serial address, 5-bit modulo 20 counter, gap logic, heads.
// - Shifter starts at zero, sends LSB first, recirculates into MSB.
// - Serial increment: feedback is carry XOR outgoing bit; carry preset one.
// - Write switch starts 100 ms erase delay, then init pulse.
// - Init clears shifter and counter, sets write enable which runs oscillator.
// - Oscillator drives two-flop ring counter, outputs 90 degrees apart.
// - Count 19 prearms; next pulse sets word start and gates shifter out.
// - Second ring phase writes clock track pulses 800 ns apart.
// - Count 11 sets address end, stops shifting; odd parity toggles writer.
// - Count 15 enables delimiter writing, positive then negative pulse.
// - Final-segment flag sets when address end clears with carry one.
// - After final segment arm gap prepare; next word start drops write enable.
// - Read amplifier ignored for a recovery delay after writing ends.
// - Gap timed against 250 us and 350 us: short, good or long.
// - Short or long gap restarts formatting; good gap stops, job done.
// - Sync flag sets exactly when the clock begins issuing pulses.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module ttf_formatter #(
   parameter int unsigned ERASE_CYCLES   = ttf_pkg::ERASE_CYC,
   parameter int unsigned SHORT_CYCLES   = ttf_pkg::SHORT_CYC,
   parameter int unsigned LONG_CYCLES    = ttf_pkg::LONG_CYC,
   parameter int unsigned RECOVER_CYCLES = ttf_pkg::RECOVER_CYC
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // Register port
   input  wire ttf_pkg::ttf_bus_t   busReq,
   output logic [15:0]              busRdata,
   // Head electronics
   input  wire logic                readPulse,
   output ttf_pkg::ttf_heads_t      heads,
   // Status
   output logic                     syncFlag,
   output logic                     jobDone
);
   import ttf_pkg::*;

   ttf_state_t                 state;
   ttf_state_t                 next_state;
   logic                       writeSwitch;
   logic [7:0]                 quarter;
   logic [31:0]                timer;
   logic                       writeEnable;
   logic [7:0]                 tickCnt;
   logic                       ringA;
   logic                       ringB;
   logic [4:0]                 bitCell;
   logic [ADDR_W-1:0]          shifter;
   logic                       carry;
   logic                       parity;
   logic                       wordStart;
   logic                       addrEnd;
   logic                       finalSeg;
   logic                       gapPrep;
   logic                       aWr;
   logic                       bWr;
   logic                       cWr;
   logic                       delimPos;
   logic                       delimNeg;
   logic                       gapShort;
   logic                       gapGood;
   logic                       gapLong;
   logic [2:0]                 rdSync;
   logic                       readLevel;
   logic [15:0]                next_rdata;

   // Decoding and cell events
   wire initPulse  = (state == ST_ERASE) && (timer >= ERASE_CYCLES - 1);
   wire tick       = writeEnable && (32'(tickCnt) + 1 >= 32'(quarter));
   wire ringARise  = tick && !ringA && !ringB;
   wire ringBRise  = tick && ringA && !ringB;
   wire prearm     = (bitCell == CELL_PREARM);
   // The first pulse after init opens a word too, else segment zero loses its control bit
   wire [4:0] nextCell = (prearm || !syncFlag) ? CELL_START : 5'(bitCell + 5'h01);
   wire cellStart  = ringARise && (nextCell == CELL_START);
   wire cellShift  = ringARise && (nextCell >= CELL_ADDR_LO) && (nextCell <= CELL_ADDR_END);
   wire cellAEnd   = ringARise && (nextCell == CELL_ADDR_END);
   wire cellPar    = ringARise && (nextCell == CELL_PARITY);
   wire cellDelP   = ringARise && (nextCell == CELL_DELIM_P);
   wire cellDelN   = ringARise && (nextCell == CELL_DELIM_N);
   wire shiftOut   = shifter[0];
   wire feedBack   = shiftOut ^ carry;
   wire readAgree  = (rdSync[1] == rdSync[2]);
   wire readEdge   = readAgree && rdSync[1] && !readLevel;
   wire measuring  = (state == ST_MEASURE);
   wire hitShort   = measuring && readEdge && (timer < SHORT_CYCLES);
   wire hitGood    = measuring && readEdge && (timer >= SHORT_CYCLES);
   wire hitLong    = measuring && !readEdge && (timer >= LONG_CYCLES - 1);
   wire keepTimer  = (state == ST_RECOVER) && (next_state == ST_MEASURE);
   wire busWrCtrl  = busReq.wr && (busReq.addr == REG_CTRL);

   // Sequence control
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (writeSwitch) begin
               next_state = ST_ERASE;
            end
         end
         ST_ERASE: begin
            if (initPulse) begin
               next_state = ST_WRITE;
            end
         end
         ST_WRITE: begin
            if (!writeEnable) begin
               next_state = ST_RECOVER;
            end
         end
         ST_RECOVER: begin
            // The amplifier is still settling from write current here
            if (timer >= RECOVER_CYCLES - 1) begin
               next_state = ST_MEASURE;
            end
         end
         ST_MEASURE: begin
            if (hitShort || hitLong) begin
               next_state = ST_ERASE;
            end else if (hitGood) begin
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            next_state = ST_DONE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (!writeSwitch) begin
         next_state = ST_IDLE;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         timer <= 32'h0000_0000;
      end else begin
         state <= next_state;
         timer <= (next_state != state && !keepTimer) ? 32'h0000_0000 : 32'(timer + 1);
      end
   end

   // Registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         writeSwitch <= CTRL_RESET[CTRL_SWITCH];
         quarter     <= CTRL_RESET[CTRL_QTR_LSB +: 8];
      end else if (busWrCtrl) begin
         writeSwitch <= busReq.wdata[CTRL_SWITCH];
         quarter     <= busReq.wdata[CTRL_QTR_LSB +: 8];
      end
   end

   always_comb begin
      if (busReq.addr == REG_CTRL) begin
         next_rdata = {quarter, 7'h00, writeSwitch};
      end else if (busReq.addr == REG_STATUS) begin
         next_rdata = {3'h0, delimNeg, delimPos, state, gapPrep, finalSeg, gapLong,
                       gapGood, gapShort,
                       syncFlag, writeEnable, wordStart};
      end else if (busReq.addr == REG_ADDRESS) begin
         next_rdata = {5'h00, shifter};
      end else if (busReq.addr == REG_BITCELL) begin
         next_rdata = {11'h000, bitCell};
      end else begin
         next_rdata = 16'h0000;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busRdata <= 16'h0000;
      end else begin
         busRdata <= busReq.rd ? next_rdata : 16'h0000;
      end
   end

   // Write enable gates the oscillator, so all tracks stop together at the gap
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         writeEnable <= 1'b0;
      end else if (initPulse) begin
         writeEnable <= 1'b1;
      end else if ((cellStart && gapPrep) || !writeSwitch) begin
         writeEnable <= 1'b0;
      end
   end

   // Divider restarts at init so every run begins on the same phase
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tickCnt <= 8'h00;
      end else begin
         tickCnt <= (initPulse || tick) ? 8'h00 : 8'(tickCnt + 8'h01);
      end
   end

   // Two-flop ring, a quarter cell apart
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ringA <= 1'b0;
         ringB <= 1'b0;
      end else if (initPulse) begin
         ringA <= 1'b0;
         ringB <= 1'b0;
      end else if (tick) begin
         ringA <= !ringB;
         ringB <= ringA;
      end
   end

   // Sync marks the very first oscillator pulse after init
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         syncFlag <= 1'b0;
      end else if (initPulse) begin
         syncFlag <= 1'b0;
      end else if (tick) begin
         syncFlag <= 1'b1;
      end
   end

   // Bit-cell counter and serial address shifter
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bitCell <= 5'h00;
         shifter <= '0;
         carry   <= 1'b1;
      end else if (initPulse) begin
         bitCell <= 5'h00;
         shifter <= '0;
         carry   <= 1'b1;
      end else if (ringARise) begin
         bitCell <= nextCell;
         if (cellStart) begin
            carry <= 1'b1;
         end else if (cellShift) begin
            shifter <= {feedBack, shifter[ADDR_W-1:1]};
            carry   <= carry & shiftOut;
         end
      end
   end

   // Segment flags
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wordStart <= 1'b0;
         addrEnd   <= 1'b0;
         finalSeg  <= 1'b0;
         gapPrep   <= 1'b0;
         parity    <= 1'b0;
      end else if (initPulse) begin
         wordStart <= 1'b0;
         addrEnd   <= 1'b0;
         finalSeg  <= 1'b0;
         gapPrep   <= 1'b0;
         parity    <= 1'b0;
      end else if (cellStart) begin
         wordStart <= 1'b1;
         addrEnd   <= 1'b0;
         parity    <= 1'b1;
         if (addrEnd && carry) begin
            finalSeg <= 1'b1;
         end
      end else if (cellShift) begin
         parity <= parity ^ shiftOut;
         if (cellAEnd) begin
            addrEnd <= 1'b1;
            if (finalSeg) begin
               gapPrep <= 1'b1;
            end
         end
      end else if (cellPar) begin
         wordStart <= 1'b0;
      end
   end

   // Track writers; a one reverses the head current
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         aWr <= 1'b0;
      end else if (ringBRise) begin
         aWr <= !aWr;
      end
   end

   // Address track: control bit, address bits, then parity
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bWr <= 1'b0;
      end else begin
         if (cellStart) begin
            bWr <= !bWr;
         end else if (cellShift && shiftOut) begin
            bWr <= !bWr;
         end else if (cellPar && parity) begin
            bWr <= !bWr;
         end
      end
   end

   // Delimiter track, with one-clock strobes of each edge
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cWr      <= 1'b0;
         delimPos <= 1'b0;
         delimNeg <= 1'b0;
      end else begin
         delimPos <= cellDelP;
         delimNeg <= cellDelN;
         if (cellDelP) begin
            cWr <= 1'b1;
         end else if (cellDelN) begin
            cWr <= 1'b0;
         end
      end
   end

   // Read amplifier input; first stage feeds only the second
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdSync    <= 3'b000;
         readLevel <= 1'b0;
      end else begin
         rdSync <= {rdSync[1:0], readPulse};
         if (readAgree) begin
            readLevel <= rdSync[1];
         end
      end
   end

   // Gap result, held for the operator until the next measurement
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         gapShort <= 1'b0;
         gapGood  <= 1'b0;
         gapLong  <= 1'b0;
      end else if (state == ST_RECOVER) begin
         gapShort <= 1'b0;
         gapGood  <= 1'b0;
         gapLong  <= 1'b0;
      end else begin
         if (hitShort) begin
            gapShort <= 1'b1;
         end
         if (hitGood) begin
            gapGood <= 1'b1;
         end
         if (hitLong) begin
            gapLong <= 1'b1;
         end
      end
   end

   // The guard bit is a zero on data tracks, so no data head is ever driven here
   assign heads.aTrack    = aWr;
   assign heads.bTrack    = bWr;
   assign heads.cTrack    = cWr;
   assign heads.writeGate = writeEnable;
   assign heads.erase     = (state == ST_ERASE);
   assign jobDone         = (state == ST_DONE);

endmodule

// ---- test/ttf_formatter_sva.sv ----
// Purpose: Port-level checks of the timing track formatter
// Assumes: Quarter period set to one clock, so a cell is four clocks
// Notes:   Bound into every formatter instance
`timescale 1ns/10ps
module ttf_formatter_sva #(
   parameter int unsigned ERASE_CYCLES = 50,
   parameter int unsigned SHORT_CYCLES = 40,
   parameter int unsigned LONG_CYCLES  = 60
) (
   // Clock and reset
   input wire logic                clk,
   input wire logic                sys_rst,
   // Register port
   input wire ttf_pkg::ttf_bus_t   busReq,
   input wire logic [15:0]         busRdata,
   // Heads and status
   input wire logic                readPulse,
   input wire ttf_pkg::ttf_heads_t heads,
   input wire logic                syncFlag,
   input wire logic                jobDone
);
   import ttf_pkg::*;
   int unsigned eraseCnt;
   int unsigned gapCnt;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         eraseCnt <= 0;
         gapCnt   <= 0;
      end else begin
         eraseCnt <= heads.erase ? eraseCnt + 1 : 0;
         gapCnt   <= heads.writeGate ? 0 : gapCnt + 1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_delim;
      heads.cTrack[*4] ##1 !heads.cTrack;
   endsequence
   sequence s_cell_gap;
      $stable(heads.aTrack)[*3] ##1 ($changed(heads.aTrack) || !heads.writeGate);
   endsequence
   a_rdata_idle: assert property (!$past(busReq.rd) |-> busRdata == 16'h0000)
      else $error("read data outside answer cycle");
   a_erase_span: assert property ($fell(heads.erase) && heads.writeGate |-> eraseCnt == ERASE_CYCLES)
      else $error("erase delay length wrong");
   a_init_after_erase: assert property (heads.erase && eraseCnt == ERASE_CYCLES - 1
      |=> heads.writeGate && !heads.erase)
      else $error("write enable missing after erase");
   a_sync_start: assert property ($rose(heads.writeGate) |-> ##[1:8] syncFlag)
      else $error("sync flag late");
   a_clock_needs_sync: assert property ($changed(heads.aTrack) |-> syncFlag)
      else $error("clock track before sync");
   a_clock_spacing: assert property ($changed(heads.aTrack) && heads.writeGate |=> s_cell_gap)
      else $error("clock track spacing wrong");
   a_tracks_frozen: assert property (!heads.writeGate && !heads.erase
      |=> $stable(heads.aTrack) && $stable(heads.bTrack) && $stable(heads.cTrack))
      else $error("track written without write enable");
   a_delim_width: assert property ($rose(heads.cTrack) |-> s_delim)
      else $error("delimiter pulse width wrong");
   a_done_window: assert property ($rose(jobDone)
      |-> gapCnt > SHORT_CYCLES && gapCnt <= LONG_CYCLES + 8)
      else $error("good gap outside window");
   a_done_stops: assert property (jobDone |-> !heads.writeGate && !heads.erase)
      else $error("formatting continues after good gap");
endmodule

bind ttf_formatter ttf_formatter_sva #(
   .ERASE_CYCLES(ERASE_CYCLES),
   .SHORT_CYCLES(SHORT_CYCLES),
   .LONG_CYCLES (LONG_CYCLES)
) uChk (.clk(clk), .sys_rst(sys_rst), .busReq(busReq), .busRdata(busRdata),
   .readPulse(readPulse), .heads(heads), .syncFlag(syncFlag), .jobDone(jobDone));

// ---- test/ttf_disk_model.sv ----
// Purpose: Disk surface model, decodes segments and plays back the gap
// Assumes: One cell per clock-track flux change
// Notes:   Each reported word holds cells 0 to 15, cell 0 in the top bit
`timescale 1ns/10ps
module ttf_disk_model (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // Head writers and reader
   input  wire ttf_pkg::ttf_heads_t heads,
   output logic                     readPulse,
   // Decoded segment
   output logic                     segValid,
   output logic [15:0]              segBits
);
   import ttf_pkg::*;
   logic        lastA;
   logic        lastB;
   logic        lastC;
   logic [15:0] hist;
   int          gapCnt;
   wire  [15:0] nextHist = {hist[14:0], heads.bTrack ^ lastB};
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {lastA, lastB, lastC, segValid, readPulse} <= '0;
         hist    <= '0;
         segBits <= '0;
         gapCnt  <= 0;
      end else begin
         segValid <= 1'b0;
         if (heads.aTrack != lastA) begin
            // NRZ: a one is a reversal between two cells
            {lastA, lastB, lastC} <= {heads.aTrack, heads.bTrack, heads.cTrack};
            hist <= nextHist;
            if (heads.cTrack && !lastC) begin
               segValid <= 1'b1;
               segBits  <= nextHist;
            end
         end
         if (heads.writeGate)
            gapCnt <= 1;
         else if (gapCnt != 0 && gapCnt < 1000)
            gapCnt <= gapCnt + 1;
         // Stray pulse while the reader recovers
         // Then first clock pulse well inside the good window
         readPulse <= gapCnt inside {5, 6, 45, 46};
      end
   end
endmodule

// ---- test/tb_ttf_formatter.sv ----
// Purpose: Self-checking bench of the timing track formatter
// Assumes: Shortened erase and gap counts, quarter period of one clock
// Notes:   One full revolution of 2048 segments plus the wrap segment, 2049 in all, about 164k clocks
`timescale 1ns/10ps
module tb;
   import ttf_pkg::*;
   logic              clk;
   logic              sys_rst;
   ttf_bus_t          busReq;
   logic [15:0]       busRdata;
   logic              readPulse;
   ttf_heads_t        heads;
   logic              syncFlag;
   logic              jobDone;
   logic              segValid;
   logic [15:0]       segBits;
   logic              rdSeen;
   logic [15:0]       expQ[$];
   logic [15:0]       maskQ[$];
   logic [15:0]       segQ[$];
   int                failures;
   int                checks;
   int                n;

   ttf_formatter #(.ERASE_CYCLES(50), .SHORT_CYCLES(40), .LONG_CYCLES(60),
      .RECOVER_CYCLES(10)) uut (.clk(clk), .sys_rst(sys_rst), .busReq(busReq),
      .busRdata(busRdata), .readPulse(readPulse), .heads(heads), .syncFlag(syncFlag),
      .jobDone(jobDone));
   ttf_disk_model uDisk (.clk(clk), .sys_rst(sys_rst), .heads(heads),
      .readPulse(readPulse), .segValid(segValid), .segBits(segBits));

   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      checks++;
      if (seen !== expv) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, expv);
      end
   endtask

   task automatic summarize;
      if (failures == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Reads note the masked expected value, the monitor compares it
   task automatic busOp(input logic wr, input logic [3:0] a, input logic [15:0] d,
                        input logic [15:0] m);
      @(posedge clk);
      busReq <= '{addr: a, wdata: d, wr: wr, rd: !wr};
      if (!wr) begin
         expQ.push_back(d & m);
         maskQ.push_back(m);
      end
      @(posedge clk);
      busReq <= '0;
   endtask

   function automatic logic [15:0] segWord(input logic [10:0] a);
      logic [15:0] w;
      w = 16'h8000;
      for (int k = 0; k < 11; k++)
         w[14 - k] = a[k];
      w[3] = ~^a;
      return w;
   endfunction

   always @(posedge clk) rdSeen <= busReq.rd;
   always @(negedge clk) begin
      if (rdSeen === 1'b1)
         check(busRdata & maskQ.pop_front(), expQ.pop_front());
   end
   always @(posedge clk) begin
      if (segValid === 1'b1)
         check(segBits, segQ.size() ? segQ.pop_front() : 16'hxxxx);
   end

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      #10_000_000;
      failures++;
      summarize();
   end

   initial begin
      busReq  = '0;
      sys_rst = 1'b1;
      void'($urandom(70));
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      busOp(1'b0, REG_CTRL, CTRL_RESET, 16'hffff);
      busOp(1'b0, REG_STATUS, 16'h0000, 16'hffff);
      busOp(1'b0, REG_ADDRESS, 16'h0000, 16'hffff);
      busOp(1'b0, REG_BITCELL, 16'h0000, 16'hffff);
      busOp(1'b0, 4'(4 + $urandom_range(11)), 16'h0000, 16'hffff);
      busOp(1'b1, REG_STATUS, 16'($urandom), 16'h0000);
      busOp(1'b0, REG_STATUS, 16'h0000, 16'hffff);
      busOp(1'b1, REG_CTRL, 16'h0100, 16'h0000);
      busOp(1'b0, REG_CTRL, 16'h0100, 16'hffff);
      // Every address 0 to 2047, then the wrap segment before the gap
      for (n = 0; n < SEGMENTS; n++)
         segQ.push_back(segWord(11'(n)));
      segQ.push_back(segWord(11'h000));
      busOp(1'b1, REG_CTRL, 16'h0101, 16'h0000);
      busOp(1'b0, REG_STATUS, 16'h0100, 16'h0700);
      for (n = 0; n < 180000 && jobDone !== 1'b1; n++)
         @(posedge clk);
      check({15'h0000, jobDone}, 16'h0001);
      check(16'(segQ.size()), 16'h0000);
      busOp(1'b0, REG_STATUS, 16'h0510, 16'h073a);
      busOp(1'b1, REG_CTRL, 16'h0100, 16'h0000);
      busOp(1'b0, REG_STATUS, 16'h0000, 16'h0700);
      repeat (3) @(posedge clk);
      summarize();
   end
endmodule
